// *** rol_defs.vh ***
// constants and overview for the reset option loader
//
// Overview of operation
// - reset puts every register except the pin synchronisers in defined state
// - hold processor stalled until configuration copied
// - double fault on any fetch leaves protection active; security follows the pin only
// - reset aborts running program or erase command
// - on-chip RAM is never cleared by reset
// - watchdog rate loads inverse of option bits
// - window enable loads inverse of option bit3
// - option register read from fixed flash address
// - secured special reset forces rate 111
// - periodic trim loads info row bits 5:0
// - reserved regulator addresses read as zero
// - reserved regulator writes are ignored
// - reserved regulator accesses never abort
// - high temperature trim loaded from flash
`ifndef ROL_DEFS_VH
`define ROL_DEFS_VH

`define ROL_FADDR_W        23
`define ROL_OPT_ADDR       23'h07ff0e
`define ROL_TRIM_ADDR      23'h4000f0
`define ROL_HTT_ADDR       23'h4000f1
`define ROL_RATE_LONGEST   3'h7
`define ROL_OPT_RESET      8'hff
`define ROL_TRIM_RESET     6'h00
`define ROL_HTT_RESET      4'h0
`define ROL_HTT_SPEC       4'h8

`define ROL_REG_STATUS     12'h000
`define ROL_REG_WDOG       12'h004
`define ROL_REG_OPTION     12'h008
`define ROL_REG_TRIM       12'h00c
`define ROL_REG_HTT        12'h010
`define ROL_REG_VOLTAGE_REGULATOR_UNIT_LO    12'h100
`define ROL_REG_VOLTAGE_REGULATOR_UNIT_HI    12'h1fc
`define ROL_REG_RAW_OPT    12'h020
`define ROL_REG_RAW_TRIM   12'h024
`define ROL_REG_RAW_HTT    12'h028

`define ROL_IDX_OPT        2'h0
`define ROL_IDX_TRIM       2'h1
`define ROL_IDX_HTT        2'h2
`define ROL_IDX_SPARE      2'h3

`define ROL_ST_BUSY        0
`define ROL_ST_DFAULT      1
`define ROL_ST_SECURED     2
`define ROL_ST_ABORTED     3

`endif

// *** rol_fetch.v ***
// flash fetch sequencer for reset-time loading
`timescale 1ns/100ps
module rol_fetch #(
   parameter AW = 23
) (
   input  wire          hclk,
   input  wire          hresetn,
   input  wire          start,
   input  wire [AW-1:0] addr_in,
   output reg  [AW-1:0] flash_addr,
   output reg           flash_req,
   input  wire          flash_ack,
   input  wire [7:0]    flash_data,
   input  wire          flash_dfault,
   output reg  [7:0]    data_out,
   output reg           fault_out,
   output reg           done
);
   // one byte per request; ack may take any number of cycles
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         flash_addr <= {AW{1'b0}};
         flash_req  <= 1'b0;
         data_out   <= 8'h00;
         fault_out  <= 1'b0;
         done       <= 1'b0;
      end else begin
         done <= 1'b0;
         if (start && !flash_req) begin
            flash_addr <= addr_in;
            flash_req  <= 1'b1;
         end else if (flash_req && flash_ack) begin
            flash_req <= 1'b0;
            data_out  <= flash_data;
            fault_out <= flash_dfault;
            done      <= 1'b1;
         end
      end
   end
endmodule // rol_fetch

// *** rol_regs.v ***
// small register store for loaded configuration words
`timescale 1ns/100ps
module rol_regs #(
   parameter DEPTH = 4,
   parameter AW    = 2
) (
   input  wire          hclk,
   input  wire          hresetn,
   input  wire          we,
   input  wire [AW-1:0] waddr,
   input  wire [7:0]    wdata,
   input  wire [AW-1:0] raddr,
   output reg  [7:0]    rdata
);
   reg [7:0] mem [0:DEPTH-1];
   integer i;
   // written only by the loader, never by software
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         for (i = 0; i < DEPTH; i = i + 1)
            mem[i] <= 8'h00;
         rdata <= 8'h00;
      end else begin
         if (we)
            mem[waddr] <= wdata;
         rdata <= mem[raddr];
      end
   end
endmodule // rol_regs

// *** rol_top.v ***
// reset option loader with ahb-lite register view
`timescale 1ns/100ps
`include "rol_defs.vh"
module rol_top (
   input  wire                    hclk,
   input  wire                    hresetn,
   input  wire                    hsel,
   input  wire [11:0]             haddr,
   input  wire [1:0]              htrans,
   input  wire                    hwrite,
   input  wire [2:0]              hsize,
   input  wire [31:0]             hwdata,
   input  wire                    hready,
   output reg  [31:0]             hrdata,
   output wire                    hreadyout,
   output wire                    hresp,
   output wire [`ROL_FADDR_W-1:0] flash_addr,
   output wire                    flash_req,
   input  wire                    flash_ack,
   input  wire [7:0]              flash_data,
   input  wire                    flash_dfault,
   input  wire                    flash_cmd_busy,
   output reg                     flash_cmd_abort,
   input  wire                    secured_pin,
   input  wire                    special_mode_pin,
   output wire                    cpu_stall,
   output reg  [2:0]              watchdog_rate_select,
   output reg                     watchdog_window_enable,
   output reg  [7:0]              flash_option_reg,
   output reg  [5:0]              periodic_int_trim_reg,
   output reg  [3:0]              high_temp_trim_field,
   output reg                     protect_active
);
   localparam S_ABORT = 5'h01;
   localparam S_OPT   = 5'h02;
   localparam S_TRIM  = 5'h04;
   localparam S_HTT   = 5'h08;
   localparam S_RUN   = 5'h10;

   reg [4:0] state;
   reg [4:0] next_state;
   reg       issued;
   reg       aborted;
   reg       secured;
   reg       special;
   reg [1:0] sec_sync;
   reg [1:0] spc_sync;
   reg [1:0] busy_sync;

   wire [7:0] fetch_data;
   wire       fetch_fault;
   wire       fetch_done;
   reg  [`ROL_FADDR_W-1:0] fetch_addr;
   wire       fetch_start;
   reg  [1:0] load_idx;
   wire [7:0] raw_rdata;

   // pins pass two flops before use; no reset here so they track pins while reset is low
   // limitation: reset must span two clocks for the first sample to be settled
   always @(posedge hclk) begin
      sec_sync  <= {sec_sync[0], secured_pin};
      spc_sync  <= {spc_sync[0], special_mode_pin};
      busy_sync <= {busy_sync[0], flash_cmd_busy};
   end

   assign cpu_stall   = (state != S_RUN);
   assign fetch_start = (state == S_OPT || state == S_TRIM || state == S_HTT) && !issued;

   always @* begin
      load_idx = `ROL_IDX_SPARE;
      case (state)
         S_OPT: begin
            fetch_addr = `ROL_OPT_ADDR;
            load_idx   = `ROL_IDX_OPT;
         end
         S_TRIM: begin
            fetch_addr = `ROL_TRIM_ADDR;
            load_idx   = `ROL_IDX_TRIM;
         end
         S_HTT: begin
            fetch_addr = `ROL_HTT_ADDR;
            load_idx   = `ROL_IDX_HTT;
         end
         default: fetch_addr = `ROL_OPT_ADDR;
      endcase
   end

   rol_fetch #(
      .AW (`ROL_FADDR_W)
   ) u_fetch (
      .hclk         (hclk),
      .hresetn      (hresetn),
      .start        (fetch_start),
      .addr_in      (fetch_addr),
      .flash_addr   (flash_addr),
      .flash_req    (flash_req),
      .flash_ack    (flash_ack),
      .flash_data   (flash_data),
      .flash_dfault (flash_dfault),
      .data_out     (fetch_data),
      .fault_out    (fetch_fault),
      .done         (fetch_done)
   );

   // whole fetched bytes kept for readback; raw window index follows haddr[3:2]
   rol_regs #(
      .DEPTH (4),
      .AW    (2)
   ) u_regs (
      .hclk    (hclk),
      .hresetn (hresetn),
      .we      (fetch_done),
      .waddr   (load_idx),
      .wdata   (fetch_data),
      .raddr   (haddr[3:2]),
      .rdata   (raw_rdata)
   );

   always @* begin
      case (state)
         S_ABORT: next_state = S_OPT;
         S_OPT:   next_state = fetch_done ? S_TRIM : S_OPT;
         S_TRIM:  next_state = fetch_done ? S_HTT : S_TRIM;
         S_HTT:   next_state = fetch_done ? S_RUN : S_HTT;
         S_RUN:   next_state = S_RUN;
         default: next_state = S_ABORT;
      endcase
   end

   // ram is outside this block and untouched here
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state                  <= S_ABORT;
         issued                 <= 1'b0;
         flash_cmd_abort        <= 1'b1;
         aborted                <= 1'b0;
         secured                <= 1'b0;
         special                <= 1'b0;
         flash_option_reg       <= `ROL_OPT_RESET;
         watchdog_rate_select   <= `ROL_RATE_LONGEST;
         watchdog_window_enable <= 1'b0;
         periodic_int_trim_reg  <= `ROL_TRIM_RESET;
         high_temp_trim_field   <= `ROL_HTT_RESET;
         protect_active         <= 1'b0;
      end else begin
         state <= next_state;
         if (state == S_ABORT) begin
            // abort held for first cycle; synced pins settled during reset
            flash_cmd_abort <= 1'b0;
            aborted         <= busy_sync[1];
            secured         <= sec_sync[1];
            special         <= spc_sync[1];
         end
         if (fetch_start)
            issued <= 1'b1;
         else if (fetch_done)
            issued <= 1'b0;
         if (fetch_done && fetch_fault)
            protect_active <= 1'b1;
         if (state == S_OPT && fetch_done) begin
            flash_option_reg <= fetch_data;
            if (secured && special)
               watchdog_rate_select <= `ROL_RATE_LONGEST;
            else
               watchdog_rate_select <= ~fetch_data[2:0];
            watchdog_window_enable <= ~fetch_data[3];
         end
         if (state == S_TRIM && fetch_done)
            periodic_int_trim_reg <= fetch_data[5:0];
         if (state == S_HTT && fetch_done)
            high_temp_trim_field <= fetch_data[3:0];
      end
   end

   // ahb-lite slave: zero wait, always okay
   reg        dp_read;
   reg [11:0] dp_addr;
   wire       take = hsel && hready && htrans[1];

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dp_read <= 1'b0;
         dp_addr <= 12'h000;
      end else begin
         dp_read <= take && !hwrite;
         if (take)
            dp_addr <= haddr;
      end
   end

   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   // all registers read-only; writes anywhere change nothing
   always @* begin
      hrdata = 32'h00000000;
      if (dp_read) begin
         case (dp_addr)
            `ROL_REG_STATUS: hrdata = {28'h0000000, aborted, secured & special,
                                       protect_active, cpu_stall};
            `ROL_REG_WDOG:   hrdata = {28'h0000000, watchdog_window_enable,
                                       watchdog_rate_select};
            `ROL_REG_OPTION: hrdata = {24'h000000, flash_option_reg};
            `ROL_REG_TRIM:   hrdata = {26'h0000000, periodic_int_trim_reg};
            `ROL_REG_HTT:    hrdata = {28'h0000000, high_temp_trim_field};
            `ROL_REG_RAW_OPT:  hrdata = {24'h000000, raw_rdata};
            `ROL_REG_RAW_TRIM: hrdata = {24'h000000, raw_rdata};
            `ROL_REG_RAW_HTT:  hrdata = {24'h000000, raw_rdata};
            default:         hrdata = 32'h00000000;
         endcase
      end
   end
endmodule // rol_top

// *** rol_assertions.sv ***
// port checker for the reset option loader
`timescale 1ns/100ps
module rol_checker (
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire logic [22:0] flash_addr,
   input wire logic        flash_req,
   input wire logic        flash_ack,
   input wire logic [7:0]  flash_data,
   input wire logic        secured_pin,
   input wire logic        special_mode_pin,
   input wire logic        cpu_stall,
   input wire logic [2:0]  watchdog_rate_select,
   input wire logic        watchdog_window_enable,
   input wire logic [7:0]  flash_option_reg,
   input wire logic [5:0]  periodic_int_trim_reg,
   input wire logic [3:0]  high_temp_trim_field
);
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   wire take = flash_req && flash_ack;
   property p_okay; hreadyout && !hresp; endproperty
   a_okay: assert property (p_okay) else $error("bus answer not okay");
   property p_stall; flash_req |-> cpu_stall; endproperty
   a_stall: assert property (p_stall) else $error("fetch without stall");
   property p_hold; flash_req && !flash_ack |=> flash_req && $stable(flash_addr); endproperty
   a_hold: assert property (p_hold) else $error("request dropped early");
   property p_rate; $fell(cpu_stall) |-> watchdog_rate_select ==
      ((secured_pin && special_mode_pin) ? 3'h7 : ~flash_option_reg[2:0]); endproperty
   a_rate: assert property (p_rate) else $error("rate wrong");
   property p_win; !cpu_stall |-> watchdog_window_enable == ~flash_option_reg[3]; endproperty
   a_win: assert property (p_win) else $error("window wrong");
   property p_opt; take && flash_addr == 23'h07ff0e |=> ##1
      flash_option_reg == $past(flash_data, 2); endproperty
   a_opt: assert property (p_opt) else $error("option not loaded");
   property p_trim; take && flash_addr == 23'h4000f0 |=> ##1
      periodic_int_trim_reg == $past(flash_data[5:0], 2); endproperty
   a_trim: assert property (p_trim) else $error("trim not loaded");
   property p_htt; take && flash_addr == 23'h4000f1 |=> ##1
      high_temp_trim_field == $past(flash_data[3:0], 2); endproperty
   a_htt: assert property (p_htt) else $error("htt not loaded");
   property p_keep; !cpu_stall |=> !flash_req && $stable(flash_option_reg)
      && $stable(periodic_int_trim_reg) && $stable(watchdog_rate_select); endproperty
   a_keep: assert property (p_keep) else $error("value reloaded");
endmodule // rol_checker

// *** rol_flash_model.sv ***
// behavioural flash array answering the fetch link
`timescale 1ns/100ps
module rol_flash_model (
   input  wire logic        hclk,
   input  wire logic [22:0] flash_addr,
   input  wire logic        flash_req,
   output logic             flash_ack,
   output logic [7:0]       flash_data,
   output logic             flash_dfault,
   input  wire logic [7:0]  opt,
   input  wire logic [7:0]  trim,
   input  wire logic [7:0]  htt,
   input  wire logic [3:0]  dly,
   input  wire logic        flt
);
   logic [3:0] cnt = 4'h0;
   initial {flash_ack, flash_data, flash_dfault} = 10'h0;
   always @(posedge hclk) begin
      if (flash_req && !flash_ack && cnt >= dly) begin
         flash_ack    <= 1'b1;
         flash_data   <= flash_addr == 23'h07ff0e ? opt : flash_addr == 23'h4000f0 ? trim :
                         flash_addr == 23'h4000f1 ? htt : 8'h00;
         flash_dfault <= flt && flash_addr == 23'h4000f0;
         cnt          <= 4'h0;
      end else begin
         // outside an answer the data byte is inverted every cycle, so it never holds steady
         flash_ack    <= 1'b0;
         flash_data   <= ~flash_data;
         flash_dfault <= 1'b0;
         cnt          <= (flash_req && !flash_ack) ? cnt + 4'h1 : 4'h0;
      end
   end
endmodule // rol_flash_model

// *** rol_top_tb.sv ***
// self-checking bench for the reset option loader
`timescale 1ns/100ps
module rol_top_tb;
   logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, busy = 0, sec = 0, spc = 0, flt = 0;
   logic [11:0] haddr = 12'h0;
   logic [1:0]  htrans = 2'h0;
   logic [2:0]  hsize = 3'h2;
   logic [31:0] hwdata = 32'h0, rd;
   logic [7:0]  opt = 8'h0, trim = 8'h0, htt = 8'h0;
   logic [3:0]  dly = 4'h0;
   wire  [31:0] hrdata;
   wire  [22:0] flash_addr;
   wire  [7:0]  fdata, optr;
   wire  [5:0]  trimr;
   wire  [3:0]  httr;
   wire  [2:0]  rate;
   wire hready, hresp, freq, fack, fflt, abort, stall, win, prot;
   int fail_count = 0, num_checks = 0;
   always #10 hclk = ~hclk;
   rol_top uut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
      .hrdata, .hreadyout(hready), .hresp, .flash_addr, .flash_req(freq), .flash_ack(fack),
      .flash_data(fdata), .flash_dfault(fflt), .flash_cmd_busy(busy), .flash_cmd_abort(abort),
      .secured_pin(sec), .special_mode_pin(spc), .cpu_stall(stall),
      .watchdog_rate_select(rate), .watchdog_window_enable(win), .flash_option_reg(optr),
      .periodic_int_trim_reg(trimr), .high_temp_trim_field(httr), .protect_active(prot));
   rol_flash_model fm (.hclk, .flash_addr, .flash_req(freq), .flash_ack(fack),
      .flash_data(fdata), .flash_dfault(fflt), .opt, .trim, .htt, .dly, .flt);
   task chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge hclk);
      {hsel, htrans, haddr, hwrite} <= {1'b1, 2'h2, a, w};
      do @(posedge hclk); while (hready !== 1'b1);
      {hsel, htrans, hwdata} <= {1'b0, 2'h0, d};
      do @(posedge hclk); while (hready !== 1'b1);
      rd = hrdata;
   endtask
   task t_load(input logic [7:0] o, input logic s, input logic p, input logic b,
               input logic f, input logic [3:0] dl);
      logic [2:0] er;
      er = (s & p) ? 3'h7 : ~o[2:0];
      @(posedge hclk);
      {hresetn, opt, sec, spc, busy, flt, dly} <= {1'b0, o, s, p, b, f, dl};
      trim <= o ^ 8'hc3;
      htt <= o ^ 8'h3a;
      repeat (12) @(posedge hclk);
      chk(stall, 1'b1);
      chk(abort, 1'b1);
      hresetn <= 1'b1;
      repeat (200) if (stall !== 1'b0) @(posedge hclk);
      busy <= 1'b0;
      chk(abort, 1'b0);
      chk({rate, win, optr}, {er, ~o[3], o});
      chk({trimr, httr, prot}, {trim[5:0], htt[3:0], f});
      xfer(1'b0, 12'h004, 32'h0);
      chk(rd, {28'h0, ~o[3], er});
      xfer(1'b0, 12'h000, 32'h0);
      chk(rd, {28'h0, b, s & p, f, 1'b0});
      $display("load test %h done", o);
   endtask
   task t_voltage_regulator_unit;
      xfer(1'b1, 12'h100, 32'hffffffff);
      xfer(1'b1, 12'h008, 32'h0);
      xfer(1'b0, 12'h100, 32'h0);
      chk(rd, 32'h0);
      xfer(1'b0, 12'h1fc, 32'h0);
      chk(rd, 32'h0);
      xfer(1'b0, 12'h008, 32'h0);
      chk(rd, {24'h0, opt});
      xfer(1'b0, 12'h00c, 32'h0);
      chk(rd, {26'h0, trim[5:0]});
      xfer(1'b0, 12'h010, 32'h0);
      chk(rd, {28'h0, htt[3:0]});
      xfer(1'b0, 12'h020, 32'h0);
      chk(rd, {24'h0, opt});
      xfer(1'b0, 12'h024, 32'h0);
      chk(rd, {24'h0, trim});
      xfer(1'b0, 12'h028, 32'h0);
      chk(rd, {24'h0, htt});
      $display("reserved space test done");
   endtask
   task close_out;
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   initial begin
      for (int i = 0; i < 8; i++)
         t_load({4'h5, i[0], i[2:0]}, i == 4, i == 5, i == 1, i == 2, i[3:0]);
      t_load(8'h0a, 1'b1, 1'b1, 1'b1, 1'b1, 4'h3);
      t_voltage_regulator_unit;
      close_out;
   end
   initial begin
      // whole run is about 400 cycles
      #400000;
      fail_count++;
      close_out;
   end
endmodule // rol_top_tb
bind rol_top rol_checker chk_i (.hclk, .hresetn, .hreadyout, .hresp, .flash_addr, .flash_req,
   .flash_ack, .flash_data, .secured_pin, .special_mode_pin, .cpu_stall,
   .watchdog_rate_select, .watchdog_window_enable, .flash_option_reg,
   .periodic_int_trim_reg, .high_temp_trim_field);
